// ### src/smm_pkg.sv
package smm_pkg;
  // Processor address map windows, top address nibbles
  localparam logic [31:0] BOOT_ADDR = 32'h0000_0000;
  localparam logic [3:0] REGION_FLASH = 4'h0;
  localparam logic [5:0] REGION_TCM_TOP = 6'h01;
  localparam logic [31:0] TCM_BASE = 32'h0400_0000;
  localparam logic [3:0] REGION_BUF = 4'h4;
  localparam logic [3:0] REGION_NOBUF = 4'h5;
  localparam logic [3:0] REGION_BUF_PERI = 4'h6;
  localparam logic [3:0] REGION_NOBUF_PERI = 4'h7;
  localparam logic [31:0] BUF_BASE = 32'h4000_0000;
  localparam logic [31:0] NOBUF_BASE = 32'h5000_0000;
  // Peripheral bridge windows inside the system bus space
  localparam logic [31:0] BRIDGE0_BASE = 32'h5800_0000;
  localparam logic [31:0] BRIDGE1_BASE = 32'h5c00_0000;
  localparam logic [31:0] BRIDGE_SPAN_MASK = 32'h03ff_ffff;
  // Offset inside an alias range, folding buffered onto non-buffered
  localparam logic [31:0] ALIAS_OFFSET_MASK = 32'h0fff_ffff;
  // Register map
  localparam logic [11:0] REG_CONTROL = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam logic [11:0] REG_BANK0_CFG = 12'h008;
  localparam logic [11:0] REG_BANK1_CFG = 12'h00c;
  localparam int CTRL_BUFFER_EN_BIT = 3;
  localparam int CTRL_SRAM_SIZE_LSB = 4;
  localparam logic [1:0] SRAM_SIZE_32K = 2'h0;
  localparam logic [1:0] SRAM_SIZE_64K = 2'h1;
  localparam logic [1:0] SRAM_SIZE_96K = 2'h2;
  localparam logic [31:0] SRAM_BYTES_32K = 32'h0000_8000;
  localparam logic [31:0] SRAM_BYTES_64K = 32'h0001_0000;
  localparam logic [31:0] SRAM_BYTES_96K = 32'h0001_8000;
  localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
  localparam logic [31:0] BANK_CFG_RESET = 32'h0000_0000;
  localparam int BANK_ENABLE_BIT = 0;
  localparam int BANK_BASE_LSB = 12;
  localparam int FIFO_DEPTH = 4;
  // Target selectors
  typedef enum logic [2:0] {
    SMM_TGT_NONE, SMM_TGT_FLASH, SMM_TGT_TCM, SMM_TGT_SYS,
    SMM_TGT_BRIDGE0, SMM_TGT_BRIDGE1
  } smm_target_type;
endpackage

// ### src/smm_router.sv
// The implementer's own choices: the APB slave port and the register offsets.
module smm_router #(
  parameter int DEPTH = smm_pkg::FIFO_DEPTH,
  parameter logic [1:0] MAX_SRAM_SIZE = smm_pkg::SRAM_SIZE_96K
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  // Processor request (same clock domain)
  input wire logic cpu_req,
  input wire logic cpu_write,
  input wire logic [31:0] cpu_addr,
  input wire logic [31:0] cpu_wdata,
  output logic cpu_ready,
  output logic [31:0] cpu_rdata,
  // Other bus master (DMA), always direct
  input wire logic dma_req,
  input wire logic dma_write,
  input wire logic [31:0] dma_addr,
  input wire logic [31:0] dma_wdata,
  output logic dma_ready,
  output logic [31:0] dma_rdata,
  // Flash bank ports: per-bank select, ready and read data; write, address and write data shared
  output logic flash0_sel,
  output logic flash1_sel,
  output logic flash_write,
  output logic [31:0] flash_addr,
  output logic [31:0] flash_wdata,
  input wire logic flash0_ready,
  input wire logic flash1_ready,
  input wire logic [31:0] flash0_rdata,
  input wire logic [31:0] flash1_rdata,
  // Data tightly coupled port
  output logic tcm_sel,
  output logic tcm_write,
  output logic [31:0] tcm_addr,
  output logic [31:0] tcm_wdata,
  input wire logic [31:0] tcm_rdata,
  // System bus target port
  output logic sys_sel,
  output logic sys_write,
  output logic [31:0] sys_addr,
  output logic [31:0] sys_wdata,
  output logic [1:0] sys_bridge,
  input wire logic sys_ready,
  input wire logic [31:0] sys_rdata,
  // Non-volatile boot select and its test-port write path
  input wire logic test_boot_we,
  input wire logic test_boot_value,
  output logic boot_select,
  // APB register slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic pslverr,
  output logic [31:0] prdata
);

  // Reset release synchroniser
  logic rst_meta;
  logic rst_n;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // Test port strobes are asynchronous pins
  logic tb_we_m, tb_we_s, tb_val_m, tb_val_s, tb_we_d;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tb_we_m <= 1'b0;
      tb_we_s <= 1'b0;
      tb_val_m <= 1'b0;
      tb_val_s <= 1'b0;
      tb_we_d <= 1'b0;
    end else begin
      tb_we_m <= test_boot_we;
      tb_we_s <= tb_we_m;
      tb_val_m <= test_boot_value;
      tb_val_s <= tb_val_m;
      tb_we_d <= tb_we_s;
    end
  end

  // Boot select is non-volatile: it starts erased and no reset clears it,
  // so the choice survives every reset until the test port rewrites it
  logic nv_boot = 1'b0;
  always_ff @(posedge ref_clk) begin
    if (tb_we_s && !tb_we_d) begin
      nv_boot <= tb_val_s;
    end
  end
  assign boot_select = nv_boot;

  // Registers
  logic [31:0] control;
  logic [31:0] bank_cfg [2];
  logic buffer_en;
  logic [1:0] sram_size;
  assign buffer_en = control[smm_pkg::CTRL_BUFFER_EN_BIT];
  assign sram_size = control[smm_pkg::CTRL_SRAM_SIZE_LSB +: 2];

  logic apb_wr;
  assign apb_wr = psel && penable && pwrite;
  assign pready = 1'b1;
  logic addr_ok;
  assign addr_ok = (paddr == smm_pkg::REG_CONTROL) ||
                   (paddr == smm_pkg::REG_STATUS) ||
                   (paddr == smm_pkg::REG_BANK0_CFG) ||
                   (paddr == smm_pkg::REG_BANK1_CFG);
  assign pslverr = psel && penable && !addr_ok;

  // Control register; size above the variant's maximum is ignored
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      control <= smm_pkg::CONTROL_RESET;
    end else if (apb_wr && paddr == smm_pkg::REG_CONTROL) begin
      control[smm_pkg::CTRL_BUFFER_EN_BIT] <=
        pwdata[smm_pkg::CTRL_BUFFER_EN_BIT];
      if (pwdata[smm_pkg::CTRL_SRAM_SIZE_LSB +: 2] <= MAX_SRAM_SIZE) begin
        control[smm_pkg::CTRL_SRAM_SIZE_LSB +: 2] <=
          pwdata[smm_pkg::CTRL_SRAM_SIZE_LSB +: 2];
      end
    end
  end

  // Bank config: enable bit and base; reset clears both, boot bank enabled at zero in the first cycle after release
  logic [31:0] bank_base [2];
  logic bank_en [2];
  logic was_rst;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      was_rst <= 1'b1;
    end else begin
      was_rst <= 1'b0;
    end
  end
  for (genvar b = 0; b < 2; b++) begin : g_bank
    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        bank_cfg[b] <= smm_pkg::BANK_CFG_RESET;
      end else if (was_rst) begin
        // Boot bank at zero, the other off, caught after release
        bank_cfg[b][smm_pkg::BANK_ENABLE_BIT] <=
          (boot_select == 1'(b));
      end else if (apb_wr && paddr == (b == 0 ? smm_pkg::REG_BANK0_CFG :
                                       smm_pkg::REG_BANK1_CFG)) begin
        bank_cfg[b] <= pwdata;
      end
    end
    assign bank_en[b] = bank_cfg[b][smm_pkg::BANK_ENABLE_BIT];
    assign bank_base[b] = {bank_cfg[b][31:smm_pkg::BANK_BASE_LSB],
                           12'h000};
  end

  // Write FIFO of posted processor writes, in issue order
  localparam int AW = $clog2(DEPTH);
  logic [31:0] fifo_addr [DEPTH];
  logic [31:0] fifo_data [DEPTH];
  logic [AW-1:0] wr_ptr, rd_ptr;
  logic [AW:0] count;
  logic fifo_full, fifo_empty, push, pop;
  assign fifo_full = (count == (AW+1)'(DEPTH));
  assign fifo_empty = (count == '0);

  // Status register shows live buffer state
  always_comb begin
    prdata = 32'h0000_0000;
    if (psel && !pwrite) begin
      case (paddr)
        smm_pkg::REG_CONTROL: prdata = control;
        smm_pkg::REG_STATUS:
          prdata = {28'h0000_000, boot_select, fifo_full, fifo_empty, 1'b0}
                   | (32'(count) << 8);
        smm_pkg::REG_BANK0_CFG: prdata = bank_cfg[0];
        smm_pkg::REG_BANK1_CFG: prdata = bank_cfg[1];
        default: prdata = 32'h0000_0000;
      endcase
    end
  end

  // Processor decode
  logic [3:0] nib;
  assign nib = cpu_addr[31:28];
  logic [31:0] sram_bytes;
  always_comb begin
    case (sram_size)
      smm_pkg::SRAM_SIZE_64K: sram_bytes = smm_pkg::SRAM_BYTES_64K;
      smm_pkg::SRAM_SIZE_96K: sram_bytes = smm_pkg::SRAM_BYTES_96K;
      default: sram_bytes = smm_pkg::SRAM_BYTES_32K;
    endcase
  end
  logic is_tcm, is_buf_alias, is_sys, posted;
  logic [31:0] sys_phys;
  assign is_tcm = cpu_addr[31:26] == smm_pkg::REGION_TCM_TOP &&
    (cpu_addr - smm_pkg::TCM_BASE) < sram_bytes;
  assign is_buf_alias = (nib == smm_pkg::REGION_BUF) ||
                        (nib == smm_pkg::REGION_BUF_PERI);
  assign is_sys = is_buf_alias || (nib == smm_pkg::REGION_NOBUF) ||
                  (nib == smm_pkg::REGION_NOBUF_PERI);
  // Both aliases fold onto the non-buffered address
  assign sys_phys = smm_pkg::NOBUF_BASE |
    (cpu_addr & smm_pkg::ALIAS_OFFSET_MASK) |
    {3'b000, nib[1], 28'h000_0000};
  assign posted = cpu_req && cpu_write && is_sys && is_buf_alias &&
                  buffer_en;

  // Flash bank match: bank enabled and address at or above its base
  logic hit0, hit1;
  // The tightly coupled window shadows flash in the lowest region
  assign hit0 = bank_en[0] && nib == smm_pkg::REGION_FLASH && !is_tcm &&
                cpu_addr >= bank_base[0] &&
                !(bank_en[1] && bank_base[1] > bank_base[0] &&
                  cpu_addr >= bank_base[1]);
  assign hit1 = bank_en[1] && nib == smm_pkg::REGION_FLASH &&
                cpu_addr >= bank_base[1] && !hit0 && !is_tcm;

  // Bridge selection from the system bus address, folded for processor and drain traffic, raw for DMA
  logic [1:0] bridge_of;
  function automatic logic [1:0] bridge_sel(input logic [31:0] a);
    if ((a & ~smm_pkg::BRIDGE_SPAN_MASK) == smm_pkg::BRIDGE0_BASE)
      return 2'h1;
    else if ((a & ~smm_pkg::BRIDGE_SPAN_MASK) == smm_pkg::BRIDGE1_BASE)
      return 2'h2;
    else
      return 2'h0;
  endfunction

  // System bus arbiter: direct traffic first, drain when idle
  typedef enum logic [1:0] {SMM_IDLE, SMM_CPU, SMM_DMA, SMM_DRAIN}
    smm_state_type;
  smm_state_type state, next_state;
  logic cpu_direct;
  assign cpu_direct = cpu_req && is_sys && !posted;
  // A direct write to the same location must not overtake posted data
  logic cpu_go;
  assign cpu_go = cpu_direct && (fifo_empty || !cpu_write);

  always_comb begin
    next_state = state;
    case (state)
      SMM_IDLE: begin
        if (cpu_go) next_state = SMM_CPU;
        else if (dma_req) next_state = SMM_DMA;
        else if (!fifo_empty) next_state = SMM_DRAIN;
      end
      SMM_CPU, SMM_DMA, SMM_DRAIN: begin
        if (sys_ready) next_state = SMM_IDLE;
      end
      default: next_state = SMM_IDLE;
    endcase
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) state <= SMM_IDLE;
    else state <= next_state;
  end

  assign push = posted && !fifo_full;
  assign pop = state == SMM_DRAIN && sys_ready;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      if (pop) rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
  always_ff @(posedge ref_clk) begin
    if (push) begin
      fifo_addr[wr_ptr] <= sys_phys;
      fifo_data[wr_ptr] <= cpu_wdata;
    end
  end

  // System bus outputs, combinational from the active owner
  always_comb begin
    sys_sel = state != SMM_IDLE;
    sys_write = 1'b0;
    sys_addr = 32'h0000_0000;
    sys_wdata = 32'h0000_0000;
    case (state)
      SMM_CPU: begin
        sys_write = cpu_write;
        sys_addr = sys_phys;
        sys_wdata = cpu_wdata;
      end
      SMM_DMA: begin
        sys_write = dma_write;
        sys_addr = dma_addr;
        sys_wdata = dma_wdata;
      end
      SMM_DRAIN: begin
        sys_write = 1'b1;
        sys_addr = fifo_addr[rd_ptr];
        sys_wdata = fifo_data[rd_ptr];
      end
      default: sys_sel = 1'b0;
    endcase
  end
  assign bridge_of = bridge_sel(sys_addr);
  assign sys_bridge = bridge_of;

  // Flash and tightly coupled ports are separate from the system bus
  assign flash0_sel = cpu_req && hit0;
  assign flash1_sel = cpu_req && hit1;
  assign flash_write = cpu_write;
  assign flash_addr = cpu_addr - (hit1 ? bank_base[1] : bank_base[0]);
  assign flash_wdata = cpu_wdata;
  assign tcm_sel = cpu_req && is_tcm;
  assign tcm_write = cpu_write;
  assign tcm_addr = cpu_addr - smm_pkg::TCM_BASE;
  assign tcm_wdata = cpu_wdata;

  // Processor handshake
  always_comb begin
    if (!cpu_req) cpu_ready = 1'b0;
    else if (posted) cpu_ready = !fifo_full;
    else if (is_sys) cpu_ready = state == SMM_CPU && sys_ready;
    else if (hit0) cpu_ready = flash0_ready;
    else if (hit1) cpu_ready = flash1_ready;
    else cpu_ready = 1'b1;
  end
  assign dma_ready = state == SMM_DMA && sys_ready;

  // Read data registered one cycle after the access
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cpu_rdata <= 32'h0000_0000;
      dma_rdata <= 32'h0000_0000;
    end else begin
      if (cpu_ready && !cpu_write) begin
        if (is_sys) cpu_rdata <= sys_rdata;
        else if (is_tcm) cpu_rdata <= tcm_rdata;
        else if (hit0) cpu_rdata <= flash0_rdata;
        else if (hit1) cpu_rdata <= flash1_rdata;
        else cpu_rdata <= 32'h0000_0000;
      end
      if (dma_ready && !dma_write) dma_rdata <= sys_rdata;
    end
  end

endmodule // smm_router

// ### verification/smm_far_model.sv
module smm_far_model (
  input wire logic ref_clk,
  input wire logic [7:0] wait_cycles,
  input wire logic sys_sel,
  input wire logic sys_write,
  input wire logic [31:0] sys_addr,
  input wire logic [31:0] sys_wdata,
  output logic sys_ready,
  output logic [31:0] sys_rdata,
  input wire logic flash0_sel,
  input wire logic flash1_sel,
  output logic flash0_ready,
  output logic flash1_ready,
  output logic [31:0] flash0_rdata,
  output logic [31:0] flash1_rdata,
  input wire logic [31:0] tcm_addr,
  output logic [31:0] tcm_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cnt = 8'h00;
  logic [31:0] noise = 32'h0000_0000;
  logic [31:0] mem [64];
  logic [31:0] log_q [$];
  // Slow target; idle system and flash read lines churn so stale data never looks valid
  assign sys_ready = sys_sel && cnt == wait_cycles;
  assign sys_rdata = sys_ready ? mem[sys_addr[7:2]] : noise;
  assign flash0_ready = flash0_sel;
  assign flash1_ready = flash1_sel;
  assign flash0_rdata = flash0_sel ? 32'hf0f0_0000 : noise;
  assign flash1_rdata = flash1_sel ? 32'hf1f1_0000 : ~noise;
  assign tcm_rdata = 32'h7c70_0000 | tcm_addr;
  // Wait counter restarts per transfer; writes are logged in order
  always @(posedge ref_clk) begin
    noise <= noise + 32'h0101_0101;
    cnt <= (sys_sel && !sys_ready) ? cnt + 8'h01 : 8'h00;
    if (sys_ready && sys_write) begin
      mem[sys_addr[7:2]] <= sys_wdata;
      log_q.push_back(sys_wdata);
    end
  end
endmodule // smm_far_model

// ### verification/smm_router_asserts.sv
module smm_router_asserts (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic cpu_req,
  input wire logic cpu_write,
  input wire logic [31:0] cpu_addr,
  input wire logic cpu_ready,
  input wire logic dma_req,
  input wire logic dma_write,
  input wire logic [31:0] dma_addr,
  input wire logic dma_ready,
  input wire logic flash0_sel,
  input wire logic flash1_sel,
  input wire logic tcm_sel,
  input wire logic sys_sel,
  input wire logic sys_write,
  input wire logic [1:0] sys_bridge,
  input wire logic sys_ready,
  input wire logic test_boot_we,
  input wire logic boot_select,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr
);
  timeunit 1ns;
  timeprecision 1ns;
  logic ctrl_set;
  // Until control is written, buffering cannot be on
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_set <= 1'b0;
    end else if (psel && penable && pwrite &&
                 paddr == smm_pkg::REG_CONTROL) begin
      ctrl_set <= 1'b1;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  boot_flash_a: assert property (
    cpu_req && !cpu_write && cpu_addr == smm_pkg::BOOT_ADDR &&
    !boot_select |-> flash0_sel && !flash1_sel)
    else $error("boot fetch missed bank zero");
  tcm_route_a: assert property (
    cpu_req && cpu_addr[31:26] == smm_pkg::REGION_TCM_TOP &&
    cpu_addr[25:15] == 11'h000 |->
    tcm_sel && cpu_ready && !flash0_sel && !flash1_sel)
    else $error("tcm window not on data port");
  posted_off_a: assert property (
    !ctrl_set && cpu_req && cpu_write && cpu_ready &&
    cpu_addr[31:28] == smm_pkg::REGION_BUF |->
    sys_sel && sys_write && sys_ready) else $error("posted while off");
  direct_write_a: assert property (
    cpu_req && cpu_write && cpu_ready &&
    cpu_addr[31:28] == smm_pkg::REGION_NOBUF |->
    sys_sel && sys_write && sys_ready) else $error("direct write early");
  dma_direct_a: assert property (
    dma_req && dma_write && dma_ready && dma_addr[31:30] == 2'b01 |->
    sys_sel && sys_write && sys_ready) else $error("dma write buffered");
  bridge_pick_a: assert property (
    cpu_req && cpu_ready && !cpu_write && cpu_addr[31:27] == 5'h0b |->
    sys_bridge == {cpu_addr[26], !cpu_addr[26]})
    else $error("wrong peripheral bridge");
  read_direct_a: assert property (
    cpu_req && cpu_ready && !cpu_write && cpu_addr[31:30] == 2'b01 |->
    sys_sel && !sys_write && sys_ready) else $error("read not direct");
  boot_stable_a: assert property (
    !test_boot_we [*6] |=> $stable(boot_select))
    else $error("boot select moved without test port");
  cover property (cpu_req && cpu_write && cpu_ready && !sys_sel);
  cover property ($rose(boot_select));
  cover property (dma_req && dma_ready);
  cover property (cpu_req && flash1_sel && cpu_addr == smm_pkg::BOOT_ADDR);
endmodule // smm_router_asserts

// ### verification/smm_router_tb.sv
module smm_router_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0, reset_n = 1'b0;
  logic cpu_req = 1'b0, cpu_write = 1'b0, cpu_ready;
  logic [31:0] cpu_addr = 32'h0, cpu_wdata = 32'h0, cpu_rdata;
  logic dma_req = 1'b0, dma_write = 1'b0, dma_ready;
  logic [31:0] dma_addr = 32'h0, dma_wdata = 32'h0, dma_rdata;
  logic flash0_sel, flash1_sel, flash0_ready, flash1_ready;
  logic [31:0] flash0_rdata, flash1_rdata, tcm_addr, tcm_rdata;
  logic tcm_sel, sys_sel, sys_write, sys_ready;
  logic [31:0] sys_addr, sys_wdata, sys_rdata;
  logic [1:0] sys_bridge;
  logic test_boot_we = 1'b0, test_boot_value = 1'b0, boot_select;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic pready, pslverr, err;
  logic [1:0] last_br = 2'h0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [7:0] wait_cycles = 8'h1e;
  int errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  int n;
  int c [6];
  always #25 ref_clk = ~ref_clk;
  smm_router DUT (.*, .flash_write(), .flash_addr(), .flash_wdata(),
    .tcm_write(), .tcm_wdata());
  smm_far_model u_far (.*);
  // Bridge choice of the last completed system bus transfer
  always @(posedge ref_clk) begin
    if (sys_ready) last_br <= sys_bridge;
  end
  task check(input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, seen, want);
    end
  endtask
  // Register access; data and error taken at the edge that sees pready
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Processor access; n is the number of cycles until accepted
  task cpu(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    cpu_req <= 1'b1;
    cpu_write <= w;
    cpu_addr <= a;
    cpu_wdata <= d;
    n = 0;
    do begin @(posedge ref_clk); n++; end while (cpu_ready !== 1'b1);
    cpu_req <= 1'b0;
    // Read data is registered at the accepting edge
    @(posedge ref_clk);
    rd = cpu_rdata;
  endtask
  task dma_wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    dma_req <= 1'b1;
    dma_write <= 1'b1;
    dma_addr <= a;
    dma_wdata <= d;
    n = 0;
    do begin @(posedge ref_clk); n++; end while (dma_ready !== 1'b1);
    dma_req <= 1'b0;
  endtask
  task give_verdict;
    if (errors == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Hang guard, well above the several hundred cycles the tests need
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      give_verdict();
    end
  end
  initial begin
    repeat (12) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    apb(1'b0, smm_pkg::REG_CONTROL, 32'h0);
    check(rd, smm_pkg::CONTROL_RESET);
    apb(1'b0, smm_pkg::REG_BANK0_CFG, 32'h0);
    check({31'h0, rd[0]}, 32'h1);
    apb(1'b0, smm_pkg::REG_BANK1_CFG, 32'h0);
    check({31'h0, rd[0]}, 32'h0);
    apb(1'b0, 12'hff0, 32'h0);
    check({31'h0, err}, 32'h1);
    cpu(1'b0, smm_pkg::BOOT_ADDR, 32'h0);
    check(rd, 32'hf0f0_0000);
    cpu(1'b0, 32'h0400_0010, 32'h0);
    check(rd, 32'h7c70_0010);
    check(n, 1);
    cpu(1'b1, 32'h4000_0040, 32'h11);
    check({31'h0, n > 30}, 32'h1);
    apb(1'b1, smm_pkg::REG_CONTROL, 32'h18);
    apb(1'b0, smm_pkg::REG_CONTROL, 32'h0);
    check(rd, 32'h18);
    cpu(1'b1, 32'h5000_0044, 32'h22);
    check({31'h0, n > 30}, 32'h1);
    dma_wr(32'h4000_0048, 32'h33);
    check({31'h0, n > 30}, 32'h1);
    // Six back-to-back posted writes against a slow target
    for (int i = 0; i < 6; i++) begin
      cpu(1'b1, 32'h4000_0080 + 4 * i, 32'ha0 + i);
      c[i] = n;
    end
    for (int i = 0; i < 4; i++) check(c[i], 1);
    check({31'h0, c[4] > 5 || c[5] > 5}, 32'h1);
    do apb(1'b0, smm_pkg::REG_STATUS, 32'h0); while (rd[1] !== 1'b1);
    for (int i = 0; i < 6; i++) begin
      check(u_far.log_q[u_far.log_q.size() - 6 + i], 32'ha0 + i);
    end
    cpu(1'b0, 32'h5000_0080, 32'h0);
    check(rd, 32'ha0);
    cpu(1'b0, 32'h4000_0084, 32'h0);
    check(rd, 32'ha1);
    cpu(1'b0, 32'h5800_0100, 32'h0);
    check({30'h0, last_br}, 32'h1);
    cpu(1'b0, 32'h5c00_0200, 32'h0);
    check({30'h0, last_br}, 32'h2);
    apb(1'b1, smm_pkg::REG_BANK1_CFG, 32'h0008_0001);
    apb(1'b0, smm_pkg::REG_BANK1_CFG, 32'h0);
    check(rd, 32'h0008_0001);
    cpu(1'b0, 32'h0008_0004, 32'h0);
    check(rd, 32'hf1f1_0000);
    apb(1'b1, smm_pkg::REG_STATUS, 32'h8);
    check({31'h0, boot_select}, 32'h0);
    test_boot_value <= 1'b1;
    test_boot_we <= 1'b1;
    repeat (2) @(posedge ref_clk);
    test_boot_we <= 1'b0;
    repeat (6) @(posedge ref_clk);
    apb(1'b0, smm_pkg::REG_STATUS, 32'h0);
    check({31'h0, rd[3]}, 32'h1);
    // Mid-run reset: the stored boot choice must survive and take effect
    reset_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    check({31'h0, boot_select}, 32'h1);
    apb(1'b0, smm_pkg::REG_BANK0_CFG, 32'h0);
    check({31'h0, rd[0]}, 32'h0);
    apb(1'b0, smm_pkg::REG_BANK1_CFG, 32'h0);
    check({31'h0, rd[0]}, 32'h1);
    apb(1'b0, smm_pkg::REG_CONTROL, 32'h0);
    check(rd, smm_pkg::CONTROL_RESET);
    cpu(1'b0, smm_pkg::BOOT_ADDR, 32'h0);
    check(rd, 32'hf1f1_0000);
    give_verdict();
  end
endmodule // smm_router_tb
bind smm_router smm_router_asserts u_chk (.*);
